// File: design/ebg_consts.svh
// Timing and reset constants for the external bus grant and pin sampling block
`ifndef EBG_CONSTS_SVH
`define EBG_CONSTS_SVH

`define EBG_CLK_PERIOD_PS      32'd8000
`define EBG_MIN_PULSE_NS       32'd10
`define EBG_PLL_SETTLE_CYC     32'd2000
`define EBG_RESET_PERIODS      32'd5
`define EBG_SEL_IDLE           3'h7
`define EBG_FLAG_OUT_RST       1'b0
`define EBG_SYNC_STAGES        2

`endif

// File: design/ebg_pkg.sv
// Types shared by the external bus grant block
package ebg_pkg;
    typedef enum logic [2:0] {
        EBG_OWN,
        EBG_RELEASE,
        EBG_GRANTED,
        EBG_UNGRANT,
        EBG_RECLAIM
    } ebg_state_type;
endpackage

// File: design/ebg_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`include "ebg_consts.svh"

module ebg_sync #(
    parameter int WIDTH    = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input  wire logic             CLOCK_IN,
    input  wire logic             RST_IN,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // ==========================================
    // Sync stages
    always_comb
    begin
        meta_nxt = ce_in ? d_in : meta_r;
        q_nxt    = ce_in ? meta_r : q_r;
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            meta_r <= RST_VAL;
            q_r    <= RST_VAL;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q_out = q_r;
endmodule // ebg_sync

// File: design/ebg_top.sv
// Bus request/grant arbiter with interrupt and flag input sampling
// ==========================================
// Functional notes
// R1: A bus request is recognised in the cycle it is sampled valid, else the next cycle.
// R2: Bus grant goes low one cycle after the request was recognised, never the same cycle.
// R3: The bus request is synchronised inside, so the master may drive it asynchronously.
// R4: The master holds each request low for longer than 10 ns.
// R5: Selects and strobes are released before bus grant is driven low.
// R6: Bus grant goes high before selects and strobes are enabled again.
// R7: Interrupt and flag inputs are recognised in the sampled cycle, else the next one.
// R8: A level-sensitive interrupt source holds its line low until serviced.
// R9: An edge-sensitive interrupt source gives low pulses longer than 10 ns.
// R10: After power-up the system holds reset for at least five clock-input periods; the bench releases power-up reset after four clock edges (28 ns).
// R11: The phase-locked loop settles within 2000 clock-input cycles on a stable clock.
// R12: No external access starts while granted; the bus returns only after request and grant end.
// R13: The system keeps reset asserted through the full loop settling interval; here the settle count only starts once reset is released.
`timescale 1ns/1ps
`include "ebg_consts.svh"

module ebg_top #(
    parameter int          IRQ_NUM    = 3,
    parameter logic [31:0] SETTLE_CYC = `EBG_PLL_SETTLE_CYC
) (
    input  wire logic               CLOCK_IN,
    input  wire logic               RST_IN,
    input  wire logic               CE_IN,
    input  wire logic               BUS_REQUEST_N_IN,
    input  wire logic [IRQ_NUM-1:0] EXT_INTERRUPT_N_IN,
    input  wire logic               FLAG_INPUT_IN,
    input  wire logic               FLAG_OUTPUT_SET_IN,
    input  wire logic               CORE_ACC_REQ_IN,
    input  wire logic [2:0]         CORE_SEL_N_IN,
    input  wire logic               CORE_RD_N_IN,
    input  wire logic               CORE_WR_N_IN,
    output logic                    BUS_GRANT_N_OUT,
    output logic                    MEM_DRIVE_EN_OUT,
    output logic                    DATA_MEM_SELECT_N_OUT,
    output logic                    PROG_MEM_SELECT_N_OUT,
    output logic                    BOOT_MEM_SELECT_N_OUT,
    output logic                    RD_N_OUT,
    output logic                    WR_N_OUT,
    output logic                    CORE_ACC_ALLOW_OUT,
    output logic [IRQ_NUM-1:0]      IRQ_LEVEL_OUT,
    output logic [IRQ_NUM-1:0]      IRQ_FALL_OUT,
    output logic                    FLAG_INPUT_OUT,
    output logic                    FLAG_OUTPUT_OUT,
    output logic                    READY_OUT
);
    localparam int SW = IRQ_NUM + 2;

    logic [SW-1:0]         pins_sync;
    logic                  req_act;
    logic [IRQ_NUM-1:0]    irq_act;
    logic                  flag_sync;

    ebg_pkg::ebg_state_type state_r;
    ebg_pkg::ebg_state_type state_nxt;
    logic                  grant_n_r;
    logic                  grant_n_nxt;
    logic                  drive_r;
    logic                  drive_nxt;
    logic [2:0]            sel_n_r;
    logic [2:0]            sel_n_nxt;
    logic                  rd_n_r;
    logic                  rd_n_nxt;
    logic                  wr_n_r;
    logic                  wr_n_nxt;
    logic [IRQ_NUM-1:0]    irq_lvl_r;
    logic [IRQ_NUM-1:0]    irq_lvl_nxt;
    logic [IRQ_NUM-1:0]    irq_fall_r;
    logic [IRQ_NUM-1:0]    irq_fall_nxt;
    logic                  flag_r;
    logic                  flag_nxt;
    logic                  flag_out_r;
    logic                  flag_out_nxt;
    logic [31:0]           settle_r;
    logic [31:0]           settle_nxt;
    logic                  ready;

    // ==========================================
    // Pin synchronisers
    // Async request is caught here so the master needs no synchroniser
    ebg_sync #(
        .WIDTH   (SW),
        .RST_VAL ({SW{1'b1}})
    ) u_sync (
        .CLOCK_IN (CLOCK_IN),
        .RST_IN   (RST_IN),
        .ce_in    (CE_IN),
        .d_in     ({FLAG_INPUT_IN, EXT_INTERRUPT_N_IN, BUS_REQUEST_N_IN}),
        .q_out    (pins_sync)
    ); // R3 R1 R7

    assign req_act   = ~pins_sync[0];
    assign irq_act   = ~pins_sync[IRQ_NUM:1];
    assign flag_sync = pins_sync[SW-1];
    assign ready     = (settle_r >= SETTLE_CYC);

    // ==========================================
    // Grant sequencing
    always_comb
    begin
        state_nxt   = state_r;
        grant_n_nxt = grant_n_r;
        drive_nxt   = drive_r;
        sel_n_nxt   = sel_n_r;
        rd_n_nxt    = rd_n_r;
        wr_n_nxt    = wr_n_r;
        settle_nxt  = ready ? settle_r : settle_r + 32'd1; // R11
        case (state_r)
            ebg_pkg::EBG_OWN:
            begin
                sel_n_nxt = CORE_SEL_N_IN;
                rd_n_nxt  = CORE_RD_N_IN;
                wr_n_nxt  = CORE_WR_N_IN;
                if (req_act && ready)
                begin
                    // Recognised now; grant waits one cycle, strobes go idle first
                    state_nxt = ebg_pkg::EBG_RELEASE; // R1
                    sel_n_nxt = `EBG_SEL_IDLE;
                    rd_n_nxt  = 1'b1;
                    wr_n_nxt  = 1'b1;
                    drive_nxt = 1'b0; // R5
                end
            end
            ebg_pkg::EBG_RELEASE:
            begin
                grant_n_nxt = 1'b0; // R2 R5
                state_nxt   = ebg_pkg::EBG_GRANTED;
            end
            ebg_pkg::EBG_GRANTED:
            begin
                if (!req_act)
                begin
                    grant_n_nxt = 1'b1; // R6 R12
                    state_nxt   = ebg_pkg::EBG_UNGRANT;
                end
            end
            ebg_pkg::EBG_UNGRANT:
            begin
                // Grant is already high; drive enable returns one cycle later, selects follow the core two cycles after that
                drive_nxt = 1'b1; // R6
                state_nxt = ebg_pkg::EBG_RECLAIM;
            end
            ebg_pkg::EBG_RECLAIM:
            begin
                state_nxt = ebg_pkg::EBG_OWN;
            end
            default:
            begin
                state_nxt   = ebg_pkg::EBG_OWN;
                grant_n_nxt = 1'b1;
                drive_nxt   = 1'b1;
            end
        endcase
        if (!CE_IN)
        begin
            state_nxt   = state_r;
            grant_n_nxt = grant_n_r;
            drive_nxt   = drive_r;
            sel_n_nxt   = sel_n_r;
            rd_n_nxt    = rd_n_r;
            wr_n_nxt    = wr_n_r;
            settle_nxt  = settle_r;
        end
    end

    // ==========================================
    // Interrupt and flag sampling
    always_comb
    begin
        irq_lvl_nxt  = irq_lvl_r;
        irq_fall_nxt = irq_fall_r;
        flag_nxt     = flag_r;
        flag_out_nxt = flag_out_r;
        if (CE_IN)
        begin
            irq_lvl_nxt  = irq_act; // R7 R8
            irq_fall_nxt = irq_act & ~irq_lvl_r; // R7 R9
            flag_nxt     = flag_sync; // R7
            flag_out_nxt = FLAG_OUTPUT_SET_IN;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            state_r    <= ebg_pkg::EBG_OWN;
            grant_n_r  <= 1'b1;
            drive_r    <= 1'b1;
            sel_n_r    <= `EBG_SEL_IDLE;
            rd_n_r     <= 1'b1;
            wr_n_r     <= 1'b1;
            settle_r   <= 32'd0; // R13
            irq_lvl_r  <= '0;
            irq_fall_r <= '0;
            flag_r     <= 1'b1;
            flag_out_r <= `EBG_FLAG_OUT_RST;
        end
        else
        begin
            state_r    <= state_nxt;
            grant_n_r  <= grant_n_nxt;
            drive_r    <= drive_nxt;
            sel_n_r    <= sel_n_nxt;
            rd_n_r     <= rd_n_nxt;
            wr_n_r     <= wr_n_nxt;
            settle_r   <= settle_nxt;
            irq_lvl_r  <= irq_lvl_nxt;
            irq_fall_r <= irq_fall_nxt;
            flag_r     <= flag_nxt;
            flag_out_r <= flag_out_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign BUS_GRANT_N_OUT       = grant_n_r;
    assign MEM_DRIVE_EN_OUT      = drive_r;
    assign DATA_MEM_SELECT_N_OUT = sel_n_r[0];
    assign PROG_MEM_SELECT_N_OUT = sel_n_r[1];
    assign BOOT_MEM_SELECT_N_OUT = sel_n_r[2];
    assign RD_N_OUT              = rd_n_r;
    assign WR_N_OUT              = wr_n_r;
    // Core may start an access only while we own the bus and no request is pending
    assign CORE_ACC_ALLOW_OUT    = (state_r == ebg_pkg::EBG_OWN) && !req_act && ready; // R12
    assign IRQ_LEVEL_OUT         = irq_lvl_r;
    assign IRQ_FALL_OUT          = irq_fall_r;
    assign FLAG_INPUT_OUT        = flag_r;
    assign FLAG_OUTPUT_OUT       = flag_out_r;
    assign READY_OUT             = ready;
endmodule // ebg_top

// File: verification/ebg_assertions.sv
// Concurrent checks on the bus grant and pin sampling block
`timescale 1ns/1ps

module ebg_assertions #(
    parameter int IRQ_NUM = 3
) (
    input wire logic               CLOCK_IN,
    input wire logic               RST_IN,
    input wire logic               BUS_REQUEST_N_IN,
    input wire logic [IRQ_NUM-1:0] EXT_INTERRUPT_N_IN,
    input wire logic               BUS_GRANT_N_OUT,
    input wire logic               MEM_DRIVE_EN_OUT,
    input wire logic               DATA_MEM_SELECT_N_OUT,
    input wire logic               PROG_MEM_SELECT_N_OUT,
    input wire logic               BOOT_MEM_SELECT_N_OUT,
    input wire logic               RD_N_OUT,
    input wire logic               WR_N_OUT,
    input wire logic               CORE_ACC_ALLOW_OUT,
    input wire logic [IRQ_NUM-1:0] IRQ_LEVEL_OUT,
    input wire logic [IRQ_NUM-1:0] IRQ_FALL_OUT,
    input wire logic               READY_OUT
);
    // ====================
    // Grant and sampling checks
    logic quiet;
    assign quiet = DATA_MEM_SELECT_N_OUT & PROG_MEM_SELECT_N_OUT & BOOT_MEM_SELECT_N_OUT
                 & RD_N_OUT & WR_N_OUT;
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    sequence req_taken;
        $fell(BUS_REQUEST_N_IN) && READY_OUT && BUS_GRANT_N_OUT;
    endsequence
    sequence req_dropped;
        $rose(BUS_REQUEST_N_IN) && !BUS_GRANT_N_OUT;
    endsequence
    grant_latency_a: assert property (req_taken |-> ##[3:5] !BUS_GRANT_N_OUT)
        else $error("grant late");
    grant_early_a: assert property (req_taken |-> BUS_GRANT_N_OUT [*4])
        else $error("grant early");
    release_first_a: assert property ($fell(BUS_GRANT_N_OUT) |->
        quiet && !$past(MEM_DRIVE_EN_OUT))
        else $error("grant before release");
    ungrant_first_a: assert property ($rose(BUS_GRANT_N_OUT) |-> !MEM_DRIVE_EN_OUT && quiet)
        else $error("bus enabled before ungrant");
    reclaim_order_a: assert property ($rose(MEM_DRIVE_EN_OUT) |-> $past(BUS_GRANT_N_OUT))
        else $error("bus reclaimed while granted");
    bus_quiet_a: assert property (!BUS_GRANT_N_OUT |->
        quiet && !MEM_DRIVE_EN_OUT && !CORE_ACC_ALLOW_OUT)
        else $error("access while granted");
    ungrant_time_a: assert property (req_dropped |-> ##[2:4] $rose(BUS_GRANT_N_OUT))
        else $error("grant not removed");
    irq_seen_a: assert property ($fell(EXT_INTERRUPT_N_IN[0]) |->
        ##[1:4] IRQ_LEVEL_OUT[0] && IRQ_FALL_OUT[0])
        else $error("interrupt not sampled");
    irq_pulse_a: assert property (IRQ_FALL_OUT[0] |=> !IRQ_FALL_OUT[0])
        else $error("edge pulse too long");
    ready_gate_a: assert property (!READY_OUT |-> BUS_GRANT_N_OUT)
        else $error("grant before settle");
endmodule // ebg_assertions

bind ebg_top ebg_assertions #(.IRQ_NUM(IRQ_NUM)) chk_u (
    .CLOCK_IN              (CLOCK_IN),
    .RST_IN                (RST_IN),
    .BUS_REQUEST_N_IN      (BUS_REQUEST_N_IN),
    .EXT_INTERRUPT_N_IN    (EXT_INTERRUPT_N_IN),
    .BUS_GRANT_N_OUT       (BUS_GRANT_N_OUT),
    .MEM_DRIVE_EN_OUT      (MEM_DRIVE_EN_OUT),
    .DATA_MEM_SELECT_N_OUT (DATA_MEM_SELECT_N_OUT),
    .PROG_MEM_SELECT_N_OUT (PROG_MEM_SELECT_N_OUT),
    .BOOT_MEM_SELECT_N_OUT (BOOT_MEM_SELECT_N_OUT),
    .RD_N_OUT              (RD_N_OUT),
    .WR_N_OUT              (WR_N_OUT),
    .CORE_ACC_ALLOW_OUT    (CORE_ACC_ALLOW_OUT),
    .IRQ_LEVEL_OUT         (IRQ_LEVEL_OUT),
    .IRQ_FALL_OUT          (IRQ_FALL_OUT),
    .READY_OUT             (READY_OUT)
);

// File: verification/ebg_far_master.sv
// Model of the external bus master and interrupt sources
`timescale 1ns/1ps

module ebg_far_master (
    input  wire logic  clk_in,
    input  wire logic  grant_n_in,
    output logic       req_n_out,
    output logic [2:0] irq_n_out,
    output logic       flag_out
);
    // ====================
    // Drivers
    initial
    begin
        req_n_out = 1'b1;
        irq_n_out = 3'h7;
        flag_out = 1'b0;
    end
    // Request held until grant, so it always outlasts 10 ns
    task automatic take_bus(input int hold, output int w);
        req_n_out <= 1'b0;
        w = 0;
        while (grant_n_in !== 1'b0 && w < 20)
        begin
            @(posedge clk_in);
            w++;
        end
        repeat (hold) @(posedge clk_in);
        req_n_out <= 1'b1;
    endtask
    // Two cycles make a 16 ns edge pulse; long holds stand for level mode
    task automatic pulse_irq(input int i, input int len);
        irq_n_out[i] <= 1'b0;
        repeat (len) @(posedge clk_in);
        irq_n_out[i] <= 1'b1;
    endtask
    task automatic set_flag(input logic v);
        flag_out <= v;
    endtask
endmodule // ebg_far_master

// File: verification/tb_ext_bus_grant_irq_sampling.sv
// Self-checking bench for the bus grant and pin sampling block
`timescale 1ns/1ps

module tb_ext_bus_grant_irq_sampling;
    // ====================
    // Bench
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, req_n, flag, flag_out_set = 1'b0;
    logic rd_n = 1'b1, wr_n = 1'b1;
    logic [2:0] sel_n = 3'h7, irq_n, lvl, fall;
    logic grant_n, drv_en, dsel_n, psel_n, bsel_n, rd_o, wr_o, allow, fin, fout, ready;
    int mismatches = 0, n_tests = 0, cyc = 0;

    ebg_top #(.SETTLE_CYC(32'd4)) dut_u (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .BUS_REQUEST_N_IN(req_n), .EXT_INTERRUPT_N_IN(irq_n), .FLAG_INPUT_IN(flag),
        .FLAG_OUTPUT_SET_IN(flag_out_set), .CORE_ACC_REQ_IN(1'b0), .CORE_SEL_N_IN(sel_n),
        .CORE_RD_N_IN(rd_n), .CORE_WR_N_IN(wr_n), .BUS_GRANT_N_OUT(grant_n),
        .MEM_DRIVE_EN_OUT(drv_en), .DATA_MEM_SELECT_N_OUT(dsel_n),
        .PROG_MEM_SELECT_N_OUT(psel_n), .BOOT_MEM_SELECT_N_OUT(bsel_n), .RD_N_OUT(rd_o),
        .WR_N_OUT(wr_o), .CORE_ACC_ALLOW_OUT(allow), .IRQ_LEVEL_OUT(lvl), .IRQ_FALL_OUT(fall),
        .FLAG_INPUT_OUT(fin), .FLAG_OUTPUT_OUT(fout), .READY_OUT(ready));
    ebg_far_master far_u (.clk_in(clk), .grant_n_in(grant_n), .req_n_out(req_n),
        .irq_n_out(irq_n), .flag_out(flag));

    always #4 clk = ~clk;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Core keeps a data read pending so the release is visible
    task automatic t_grant(input int hold);
        int w;
        int n;
        sel_n <= 3'h6;
        rd_n <= 1'b0;
        @(posedge clk);
        far_u.take_bus(hold, w);
        check("grant wait", 8'(w), 8'h05);
        check("bus quiet", {1'b0, drv_en, dsel_n, psel_n, bsel_n, rd_o, wr_o, allow}, 8'h3E);
        n = 0;
        while (grant_n !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        check("ungrant wait", 8'(n), 8'h04);
        check("drive held", {7'h00, drv_en}, 8'h00);
        @(posedge clk);
        check("drive back", {6'h00, drv_en, dsel_n}, 8'h03);
        // Selects follow the core one edge after the bus is owned again
        repeat (2) @(posedge clk);
        check("core pass", {5'h00, dsel_n, rd_o, allow}, 8'h01);
        sel_n <= 3'h7;
        rd_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_irq();
        int nf;
        for (int i = 0; i < 3; i++)
            for (int len = 2; len < 12; len += 8)
            begin
                nf = 0;
                far_u.pulse_irq(i, len);
                check("irq level", {7'h00, lvl[i]}, 8'(len > 2));
                repeat (6)
                begin
                    @(posedge clk);
                    nf += int'(fall[i] === 1'b1);
                end
                check("irq edge", 8'(nf), 8'(len == 2));
            end
    endtask

    task automatic t_flag();
        far_u.set_flag(1'b1);
        flag_out_set <= 1'b1;
        repeat (5) @(posedge clk);
        check("flag high", {6'h00, fin, fout}, 8'h03);
        far_u.set_flag(1'b0);
        repeat (5) @(posedge clk);
        check("flag low", {7'h00, fin}, 8'h00);
    endtask

    // Clock enable low freezes the sampled flag and the flag output
    task automatic t_ce();
        ce <= 1'b0;
        flag_out_set <= 1'b0;
        far_u.set_flag(1'b1);
        repeat (5) @(posedge clk);
        check("ce frozen", {6'h00, fin, fout}, 8'h01);
        ce <= 1'b1;
        repeat (5) @(posedge clk);
        check("ce resumed", {6'h00, fin, fout}, 8'h02);
    endtask

    // Reset after power-up, held five clock periods, then settle again
    task automatic t_reset();
        int n;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        check("reset again", {2'h0, grant_n, drv_en, ready, fout, lvl[0], fin}, 8'h31);
        rst <= 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        check("settle again", 8'(n), 8'h05);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            mismatches++;
            test_done();
        end
    end

    initial
    begin
        int n;
        repeat (2) @(posedge clk);
        check("reset", {4'h0, grant_n, drv_en, ready, fout}, 8'h0C);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        check("settle", 8'(n >= 4 && n <= 6), 8'h01);
        t_grant(0);
        t_grant(3);
        t_irq();
        t_flag();
        t_ce();
        t_reset();
        t_grant(1);
        test_done();
    end
endmodule // tb_ext_bus_grant_irq_sampling
